// ===== src/rpmc_top.sv
// Module: reset sequencer and power-mode controller
module rpmc_top #(
  parameter int POR_CYC = rpmc_pkg::POR_TIMEOUT_CYC
) (
  input  wire logic                i_mclk,
  input  wire logic                i_nrst,
  input  wire rpmc_pkg::rpmc_sfr_t i_sfr,
  input  wire logic                i_instr_end,
  input  wire logic                i_irq_pending,
  input  wire rpmc_pkg::rpmc_src_t i_src,
  input  wire logic                i_mcd_en,
  input  wire logic                i_wdt_en,
  input  wire logic                i_rst_pin_in,
  output logic [7:0]               o_sfr_rdata,
  output logic                     o_cpu_clk_en,
  output logic                     o_osc_en,
  output logic                     o_sys_rst,
  output logic                     o_rst_pin_oe_n,
  output logic                     o_rst_pin_out,
  output logic                     o_pullup_en,
  output logic [7:0]               o_port_latch,
  output logic                     o_wdt_restart,
  output logic [2:0]               o_wdt_interval,
  output logic                     o_pc_clear,
  output logic                     o_irq_wake,
  output logic [1:0]               o_baud_div2_en,
  output logic [1:0]               o_status_view
);
  import rpmc_pkg::*;

  // ---------------------------------------------------------------
  // Reset pin synchroniser: three stages, change when 2 and 3 agree
  // ---------------------------------------------------------------
  logic [2:0] pin_sync_ff;
  logic [2:0] nxt_pin_sync;
  logic       pin_low_ff;
  logic       nxt_pin_low;
  always_comb begin
    nxt_pin_sync = {pin_sync_ff[1:0], i_rst_pin_in};
    nxt_pin_low  = pin_low_ff;
    if (pin_sync_ff[2] == pin_sync_ff[1]) begin
      nxt_pin_low = ~pin_sync_ff[2];
    end
    // Own power-on drive of the pin must not read back as a pin reset
    if (!o_rst_pin_oe_n) begin
      nxt_pin_sync = 3'h7;
      nxt_pin_low  = 1'b0;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pin_sync_ff <= 3'h7;
      pin_low_ff  <= 1'b0;
    end else begin
      pin_sync_ff <= nxt_pin_sync;
      pin_low_ff  <= nxt_pin_low;
    end
  end

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  function automatic logic hit(input rpmc_sfr_t s, input logic [7:0] a);
    hit = s.wr && (s.addr == a);
  endfunction : hit

  logic       wr_pwr;
  logic       wr_src;
  logic [7:0] pwr_ff;
  logic [7:0] nxt_pwr;
  logic [6:0] flag_ff;
  logic [6:0] nxt_flag;
  logic [1:0] src_en_ff;
  logic [1:0] nxt_src_en;
  assign wr_pwr = hit(i_sfr, PWR_CTRL_ADDR);
  assign wr_src = hit(i_sfr, RST_SRC_ADDR);

  // ---------------------------------------------------------------
  // Reset source combine and sequencer
  // ---------------------------------------------------------------
  rpmc_rst_t rst_ff;
  rpmc_rst_t nxt_rst;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic [6:0]  cause_ff;
  logic [6:0]  nxt_cause;
  logic        sw_rst;
  logic        por_req;
  logic        any_int;
  logic [6:0]  hit_src;
  // Seven sources, one reset; active causes are recorded together, but a power-on request wins and records only its own flag
  always_comb begin
    sw_rst  = wr_src && i_sfr.wdata[BIT_SW_FLAG];
    por_req = i_src.supply_low || (wr_src && i_sfr.wdata[BIT_POR_FLAG]);
    hit_src = 7'h00;
    hit_src[BIT_POR_FLAG] = por_req;
    hit_src[BIT_PIN_FLAG] = pin_low_ff;
    hit_src[BIT_SW_FLAG]  = sw_rst;
    hit_src[BIT_MCD_FLAG] = i_src.missing_clock_detector && i_mcd_en;
    hit_src[BIT_WDT_FLAG] = i_src.wdt && i_wdt_en;
    hit_src[BIT_CMP_FLAG] = !i_src.cmp0_n && src_en_ff[0];
    hit_src[BIT_CNV_FLAG] = !i_src.cnv_n && src_en_ff[1];
    any_int = |hit_src;
  end
  always_comb begin
    nxt_rst   = rst_ff;
    nxt_cnt   = cnt_ff;
    nxt_cause = cause_ff;
    case (rst_ff)
      RPMC_POR: begin
        // Pin stays low for the whole supply timeout
        nxt_cause = 7'h00;
        nxt_cause[BIT_POR_FLAG] = 1'b1;
        if (por_req) begin
          nxt_cnt = 32'h0;
        end else if (cnt_ff >= 32'(POR_CYC - 1)) begin
          nxt_rst = RPMC_OUT;
        end else begin
          nxt_cnt = cnt_ff + 32'h1;
        end
      end
      RPMC_HOLD: begin
        if (por_req) begin
          nxt_rst = RPMC_POR;
          nxt_cnt = 32'h0;
        end else if (any_int) begin
          nxt_cnt   = 32'h0;
          nxt_cause = cause_ff | hit_src;
        end else if (cnt_ff >= 32'(PIN_HOLD_CYC - 1)) begin
          nxt_rst = RPMC_OUT;
        end else begin
          nxt_cnt = cnt_ff + 32'h1;
        end
      end
      default: begin
        nxt_cnt = 32'h0;
        if (por_req) begin
          nxt_rst = RPMC_POR;
        end else if (any_int) begin
          nxt_rst   = RPMC_HOLD;
          nxt_cause = hit_src;
        end
      end
    endcase
  end
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      rst_ff   <= RPMC_POR;
      cnt_ff   <= 32'h0;
      cause_ff <= 7'h00;
    end else begin
      rst_ff   <= nxt_rst;
      cnt_ff   <= nxt_cnt;
      cause_ff <= nxt_cause;
    end
  end

  // ---------------------------------------------------------------
  // Registers; power control and source enables cleared in reset, flags loaded on exit
  // ---------------------------------------------------------------
  logic in_rst;
  logic leaving;
  assign in_rst  = (rst_ff != RPMC_OUT);
  assign leaving = in_rst && (nxt_rst == RPMC_OUT);
  always_comb begin
    nxt_pwr    = pwr_ff;
    nxt_flag   = flag_ff;
    nxt_src_en = src_en_ff;
    if (in_rst) begin
      nxt_pwr    = PWR_CTRL_RESET;
      nxt_src_en = 2'h0;
      if (leaving) begin
        nxt_flag = cause_ff;
      end
    end else begin
      if (wr_pwr) begin
        // Reserved and mode bits never stored
        nxt_pwr = i_sfr.wdata & PWR_CTRL_RW_MSK;
      end
      if (wr_src) begin
        nxt_src_en = {i_sfr.wdata[BIT_CNV_FLAG], i_sfr.wdata[BIT_CMP_FLAG]};
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pwr_ff    <= PWR_CTRL_RESET;
      flag_ff   <= 7'h00;
      src_en_ff <= 2'h0;
    end else begin
      pwr_ff    <= nxt_pwr;
      flag_ff   <= nxt_flag;
      src_en_ff <= nxt_src_en;
    end
  end

  // ---------------------------------------------------------------
  // Power-mode machine; requests wait for instruction end
  // ---------------------------------------------------------------
  rpmc_mode_t mode_ff;
  rpmc_mode_t nxt_mode;
  logic [1:0] req_ff;
  logic [1:0] nxt_req;
  logic       wake;
  always_comb begin
    nxt_mode = mode_ff;
    nxt_req  = req_ff;
    wake     = 1'b0;
    if (wr_pwr) begin
      nxt_req = req_ff | {i_sfr.wdata[BIT_STOP], i_sfr.wdata[BIT_IDLE]};
    end
    case (mode_ff)
      RPMC_RUN: begin
        if (i_instr_end && nxt_req[1]) begin
          nxt_mode = RPMC_STOP;
          nxt_req  = 2'h0;
        end else if (i_instr_end && nxt_req[0]) begin
          nxt_mode = RPMC_IDLE;
          nxt_req  = 2'h0;
        end
      end
      RPMC_IDLE: begin
        if (i_irq_pending) begin
          nxt_mode = RPMC_RUN;
          wake     = 1'b1;
        end
      end
      default: nxt_mode = RPMC_STOP;
    endcase
    if (in_rst || any_int) begin
      nxt_mode = RPMC_RUN;
      nxt_req  = 2'h0;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      mode_ff <= RPMC_RUN;
      req_ff  <= 2'h0;
    end else begin
      mode_ff <= nxt_mode;
      req_ff  <= nxt_req;
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 8'h00;
    if (i_sfr.rd && i_sfr.addr == PWR_CTRL_ADDR) begin
      nxt_rdata = pwr_ff;
    end else if (i_sfr.rd && i_sfr.addr == RST_SRC_ADDR) begin
      nxt_rdata = {1'b0, flag_ff};
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_sfr_rdata    <= 8'h00;
      o_cpu_clk_en   <= 1'b0;
      o_osc_en       <= 1'b1;
      o_sys_rst      <= 1'b1;
      o_rst_pin_oe_n <= 1'b0;
      o_rst_pin_out  <= 1'b0;
      o_pullup_en    <= 1'b0;
      o_port_latch   <= PORT_RESET;
      o_wdt_restart  <= 1'b0;
      o_wdt_interval <= WDT_LONGEST;
      o_pc_clear     <= 1'b1;
      o_irq_wake     <= 1'b0;
      o_baud_div2_en <= 2'h3;
      o_status_view  <= 2'h0;
    end else begin
      o_sfr_rdata    <= nxt_rdata;
      o_cpu_clk_en   <= !(nxt_rst != RPMC_OUT) && nxt_mode == RPMC_RUN;
      o_osc_en       <= nxt_mode != RPMC_STOP;
      o_sys_rst      <= nxt_rst != RPMC_OUT;
      o_rst_pin_oe_n <= nxt_rst != RPMC_POR;
      o_rst_pin_out  <= 1'b0;
      o_pullup_en    <= nxt_rst == RPMC_OUT;
      if (nxt_rst != RPMC_OUT) begin
        o_port_latch <= PORT_RESET;
      end
      o_wdt_restart  <= leaving;
      if (nxt_rst != RPMC_OUT) begin
        o_wdt_interval <= WDT_LONGEST;
      end
      o_pc_clear     <= nxt_rst != RPMC_OUT;
      o_irq_wake     <= wake;
      o_baud_div2_en <= {~nxt_pwr[BIT_SERIAL1_BAUD_DOUBLER], ~nxt_pwr[BIT_SERIAL0_BAUD_DOUBLER]};
      o_status_view  <= {nxt_pwr[BIT_SERIAL1_STATUS_VIEW], nxt_pwr[BIT_SERIAL0_STATUS_VIEW]};
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Quiet exit from the hold state; long holds are judged by the counter
  sequence s_hold_exit;
    rst_ff == RPMC_HOLD && !any_int ##1 rst_ff == RPMC_OUT;
  endsequence
  chk_pin_hold_len: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_hold_exit |-> $past(cnt_ff) >= 32'(PIN_HOLD_CYC - 1))
    else $error("reset left before twelve cycles");
  chk_idle_entry: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    mode_ff == RPMC_RUN && req_ff[0] && !req_ff[1] && i_instr_end && !in_rst
      && !any_int |=> mode_ff == RPMC_IDLE)
    else $error("idle not entered at instruction end");
  chk_stop_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    mode_ff == RPMC_STOP && !in_rst && !any_int |=> mode_ff == RPMC_STOP)
    else $error("stop left without reset");
  chk_idle_wake: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    mode_ff == RPMC_IDLE && i_irq_pending |=> mode_ff == RPMC_RUN && o_irq_wake)
    else $error("interrupt did not end idle");
  chk_mode_bits_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    pwr_ff[1:0] == 2'h0)
    else $error("mode bits stored");
  chk_pullup_off: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    in_rst |-> !o_pullup_en)
    else $error("pull-ups on during reset");
  chk_port_high: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    $rose(in_rst) |-> ##[0:4] o_port_latch == PORT_RESET)
    else $error("ports not high within four clocks");
  chk_por_flag: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    rst_ff == RPMC_POR && nxt_rst == RPMC_OUT |=> flag_ff == 7'h02)
    else $error("power-on flag wrong");
  chk_mcd_pin: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    rst_ff == RPMC_OUT && hit_src == 7'h04 |=> ##1 o_rst_pin_oe_n)
    else $error("clock loss drove the pin");
endmodule : rpmc_top

// ===== src/rpmc_pkg.sv
// Package: constants and types of the reset and power-mode controller
package rpmc_pkg;
  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] PWR_CTRL_ADDR   = 8'h87;
  localparam logic [7:0] RST_SRC_ADDR    = 8'hef;
  localparam logic [7:0] PWR_CTRL_RESET  = 8'h00;
  localparam logic [7:0] PWR_CTRL_RW_MSK = 8'hd8;
  localparam int         BIT_IDLE        = 0;
  localparam int         BIT_STOP        = 1;
  localparam int         BIT_PIN_FLAG    = 0;
  localparam int         BIT_POR_FLAG    = 1;
  localparam int         BIT_MCD_FLAG    = 2;
  localparam int         BIT_WDT_FLAG    = 3;
  localparam int         BIT_SW_FLAG     = 4;
  localparam int         BIT_CMP_FLAG    = 5;
  localparam int         BIT_CNV_FLAG    = 6;
  localparam int         BIT_SERIAL0_BAUD_DOUBLER       = 7;
  localparam int         BIT_SERIAL0_STATUS_VIEW      = 6;
  localparam int         BIT_SERIAL1_BAUD_DOUBLER       = 4;
  localparam int         BIT_SERIAL1_STATUS_VIEW      = 3;
  localparam logic [7:0] PORT_RESET      = 8'hff;
  localparam logic [2:0] WDT_LONGEST     = 3'h7;
  localparam logic [15:0] RESET_VECTOR   = 16'h0000;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 4;
  localparam int PIN_HOLD_CYC     = 12;
  localparam int PIN_HIGH_MAX_CYC = 4;
  localparam int POR_TIMEOUT_MS   = 100;
  localparam int POR_TIMEOUT_CYC  = POR_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RPMC_RUN, RPMC_IDLE, RPMC_STOP} rpmc_mode_t;
  typedef enum logic [1:0] {RPMC_POR, RPMC_HOLD, RPMC_OUT} rpmc_rst_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpmc_sfr_t;
  typedef struct packed {
    logic supply_low;
    logic wdt;
    logic missing_clock_detector;
    logic cmp0_n;
    logic cnv_n;
  } rpmc_src_t;
endpackage : rpmc_pkg

// ===== bench/rpmc_partner.sv
// Partner model: CPU instruction timing and the pulled-up reset pin wire
module rpmc_partner (
  input  wire logic i_mclk,
  input  wire logic i_cpu_clk_en,
  input  wire logic i_sys_rst,
  input  wire logic i_pin_oe_n,
  input  wire logic i_pin_out,
  input  wire logic i_ext_low,
  output logic      o_instr_end,
  output logic      o_pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] step_ff = 2'h0;
  // Pin wire: pull-up wins unless the device or the board pulls low
  assign o_pin_level = ~((~i_pin_oe_n & ~i_pin_out) | i_ext_low);
  // Four-clock instructions; a halted CPU clock completes nothing
  always @(posedge i_mclk) begin
    if (i_sys_rst | ~i_cpu_clk_en) begin
      step_ff <= 2'h0;
    end else begin
      step_ff <= step_ff + 2'h1;
    end
  end
  assign o_instr_end = (step_ff == 2'h3);
endmodule : rpmc_partner

// ===== bench/tb.sv
// Testbench: register-level tests of the reset and power-mode controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rpmc_pkg::*;
  // Short power-on timeout keeps the run brief
  localparam int POR_SIM = 20;
  localparam logic [7:0] PC_VALS [6] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h00, 8'hd8};
  logic       i_mclk, i_nrst, i_instr_end, i_irq_pending;
  logic       i_mcd_en, i_wdt_en, i_rst_pin_in, ext_low;
  rpmc_sfr_t  i_sfr;
  rpmc_src_t  i_src;
  logic [7:0] o_sfr_rdata, o_port_latch, rd_val;
  logic       o_cpu_clk_en, o_osc_en, o_sys_rst, o_rst_pin_oe_n, o_rst_pin_out;
  logic       o_pullup_en, o_wdt_restart, o_pc_clear, o_irq_wake;
  logic [2:0] o_wdt_interval;
  logic [1:0] o_baud_div2_en, o_status_view;
  int         n_fail, checked, cyc;

  rpmc_top #(.POR_CYC(POR_SIM)) u_dut (
    .i_mclk, .i_nrst, .i_sfr, .i_instr_end, .i_irq_pending, .i_src, .i_mcd_en,
    .i_wdt_en, .i_rst_pin_in, .o_sfr_rdata, .o_cpu_clk_en, .o_osc_en, .o_sys_rst,
    .o_rst_pin_oe_n, .o_rst_pin_out, .o_pullup_en, .o_port_latch, .o_wdt_restart,
    .o_wdt_interval, .o_pc_clear, .o_irq_wake, .o_baud_div2_en, .o_status_view);

  rpmc_partner u_partner (
    .i_mclk(i_mclk), .i_cpu_clk_en(o_cpu_clk_en), .i_sys_rst(o_sys_rst),
    .i_pin_oe_n(o_rst_pin_oe_n), .i_pin_out(o_rst_pin_out), .i_ext_low(ext_low),
    .o_instr_end(i_instr_end), .o_pin_level(i_rst_pin_in));

  // Clock and hang guard; the guard far exceeds the few hundred cycles used
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  initial begin
    #80000;
    n_fail++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    finish_test();
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d, failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  // Bounded wait; leaves the cycle count in cyc
  task automatic wait_for(ref logic s, input logic v, input int lim);
    cyc = 0;
    while (s !== v && cyc < lim) begin
      @(posedge i_mclk);
      #1 cyc++;
    end
    chk1(s, v, "wait bound");
  endtask : wait_for

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_mclk);
    i_sfr <= '0;
  endtask : sfr_wr

  // Read data stands for the one cycle after the strobe
  task automatic sfr_rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_mclk);
    i_sfr <= '0;
    #1 rd_val = o_sfr_rdata;
  endtask : sfr_rd

  task automatic enter_rst(input logic drv);
    wait_for(o_sys_rst, 1'b1, 20);
    repeat (4) @(posedge i_mclk);
    #1 chk(o_port_latch, PORT_RESET, "port latch");
    chk1(o_pullup_en, 1'b0, "pull-up in reset");
    chk1(o_pc_clear, 1'b1, "pc clear");
    chk({5'h00, o_wdt_interval}, {5'h00, WDT_LONGEST}, "wdt interval");
    chk1(o_rst_pin_oe_n, ~drv, "pin drive");
    chk1(i_rst_pin_in, ~(drv | ext_low), "pin level");
    chk1(o_cpu_clk_en, 1'b0, "cpu halted in reset");
  endtask : enter_rst

  task automatic exit_chk(input logic [7:0] msk, input logic [7:0] exp);
    wait_for(o_sys_rst, 1'b0, 200);
    chk1(o_wdt_restart, 1'b1, "watchdog restart on exit");
    sfr_rd(RST_SRC_ADDR);
    chk(rd_val & msk, exp, "reset flags");
    chk1(o_pullup_en, 1'b1, "pull-up out of reset");
    chk1(o_cpu_clk_en & o_osc_en, 1'b1, "restart");
    sfr_rd(PWR_CTRL_ADDR);
    chk(rd_val & PWR_CTRL_RW_MSK, PWR_CTRL_RESET, "power control reset");
  endtask : exit_chk

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    i_nrst = 1'b0;
    i_sfr = '0;
    i_irq_pending = 1'b0;
    i_mcd_en = 1'b0;
    i_wdt_en = 1'b0;
    ext_low = 1'b0;
    i_src = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    n_fail = 0;
    checked = 0;
    repeat (20) @(posedge i_mclk);
    i_nrst <= 1'b1;
    enter_rst(1'b1);
    exit_chk(8'h02, 8'h02);
    // Writable fields and the two serial controls, read-zero mode bits
    for (int i = 0; i < 6; i++) begin
      sfr_wr(PWR_CTRL_ADDR, PC_VALS[i]);
      sfr_rd(PWR_CTRL_ADDR);
      chk(rd_val & 8'hdb, PC_VALS[i], "power control");
      chk({6'h00, o_baud_div2_en}, {6'h00, ~PC_VALS[i][4], ~PC_VALS[i][7]}, "baud");
      chk({6'h00, o_status_view}, {6'h00, PC_VALS[i][3], PC_VALS[i][6]}, "view");
    end
    // Idle, then an interrupt wakes the CPU
    sfr_wr(PWR_CTRL_ADDR, 8'h01);
    wait_for(o_cpu_clk_en, 1'b0, 8);
    chk1(o_osc_en, 1'b1, "clocks in idle");
    sfr_rd(PWR_CTRL_ADDR);
    chk(rd_val & 8'h03, 8'h00, "mode bits read zero");
    @(posedge i_mclk);
    i_irq_pending <= 1'b1;
    wait_for(o_irq_wake, 1'b1, 8);
    wait_for(o_cpu_clk_en, 1'b1, 4);
    @(posedge i_mclk);
    i_irq_pending <= 1'b0;
    i_mcd_en <= 1'b1;
    // Stop ignores interrupts; the clock-loss reset ends it
    sfr_wr(PWR_CTRL_ADDR, 8'h02);
    wait_for(o_osc_en, 1'b0, 8);
    chk1(o_cpu_clk_en, 1'b0, "cpu in stop");
    @(posedge i_mclk);
    i_irq_pending <= 1'b1;
    repeat (10) @(posedge i_mclk);
    #1 chk1(o_osc_en, 1'b0, "interrupt ignored in stop");
    @(posedge i_mclk);
    i_irq_pending <= 1'b0;
    i_src.missing_clock_detector <= 1'b1;
    enter_rst(1'b0);
    @(posedge i_mclk);
    i_src.missing_clock_detector <= 1'b0;
    i_mcd_en <= 1'b0;
    i_wdt_en <= 1'b1;
    exit_chk(8'h7f, 8'h04);
    // Watchdog ends idle
    sfr_wr(PWR_CTRL_ADDR, 8'h01);
    wait_for(o_cpu_clk_en, 1'b0, 8);
    @(posedge i_mclk);
    i_src.wdt <= 1'b1;
    enter_rst(1'b0);
    @(posedge i_mclk);
    i_src.wdt <= 1'b0;
    exit_chk(8'h7f, 8'h08);
    // Pin reset; a write while held must not land
    @(posedge i_mclk);
    ext_low <= 1'b1;
    enter_rst(1'b0);
    sfr_wr(PWR_CTRL_ADDR, 8'h90);
    @(posedge i_mclk);
    ext_low <= 1'b0;
    exit_chk(8'h7f, 8'h01);
    chk1(cyc >= PIN_HOLD_CYC, 1'b1, "pin hold");
    sfr_wr(RST_SRC_ADDR, 8'h10);
    enter_rst(1'b0);
    exit_chk(8'h7f, 8'h10);
    // Comparator, then conversion-start, as enabled active-low sources
    for (int i = 0; i < 2; i++) begin
      sfr_wr(RST_SRC_ADDR, (i != 0) ? 8'h40 : 8'h20);
      @(posedge i_mclk);
      i_src.cmp0_n <= (i != 0);
      i_src.cnv_n <= (i == 0);
      enter_rst(1'b0);
      @(posedge i_mclk);
      i_src.cmp0_n <= 1'b1;
      i_src.cnv_n <= 1'b1;
      exit_chk(8'h7f, (i != 0) ? 8'h40 : 8'h20);
    end
    sfr_wr(RST_SRC_ADDR, 8'h02);
    enter_rst(1'b1);
    exit_chk(8'h02, 8'h02);
    @(posedge i_mclk);
    i_src.supply_low <= 1'b1;
    enter_rst(1'b1);
    @(posedge i_mclk);
    i_src.supply_low <= 1'b0;
    exit_chk(8'h02, 8'h02);
    chk1(cyc >= POR_SIM, 1'b1, "supply recovery hold");
    finish_test();
  end
endmodule : tb
